// ### src/mgu_dev.sv
`timescale 1ns/10ps
`include "mgu_regs.svh"

module mgu_uart import mgu_pkg::*; #(
   parameter int DIV = mgu_div(`MGU_MAIN_BAUD)
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Transmit character
   input wire mgu_byte_t tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   // Receive character
   output mgu_byte_t rx_data_out,
   output logic rx_valid_out,
   output logic rx_err_out,
   // Serial lines
   output logic tx_line_out,
   input wire logic rx_line_in
);
   if (DIV < 4 || DIV >= (1 << `MGU_TMR_W)) begin : g_bad_div
      $error("mgu_uart divisor out of range");
   end
   localparam mgu_tmr_t RELOAD = mgu_tmr_t'(DIV - 1);
   localparam mgu_tmr_t HALF = mgu_tmr_t'(DIV / 2 - 1);
   localparam logic [3:0] FRAME = 4'(`MGU_FRAME_BITS);

   // Transmitter: shift register refills with idle level behind the frame
   logic [`MGU_FRAME_BITS-1:0] tx_sh_ff;
   logic [3:0] tx_left_ff;
   mgu_tmr_t tx_tmr_ff;
   wire logic tx_tick = tx_tmr_ff == '0;
   wire logic tx_load = tx_valid_in & tx_ready_out;
   wire logic tx_step = ~tx_ready_out & tx_tick;
   wire logic [`MGU_FRAME_BITS-1:0] nxt_tx_sh = tx_load ?
      {`MGU_STOP_BIT, tx_data_in, `MGU_START_BIT} :
      tx_step ? {`MGU_LINE_IDLE, tx_sh_ff[`MGU_FRAME_BITS-1:1]} : tx_sh_ff;
   wire logic [3:0] nxt_tx_left = tx_load ? FRAME : tx_step ? tx_left_ff - 4'h1 : tx_left_ff;
   wire mgu_tmr_t nxt_tx_tmr = (tx_load | tx_tick) ? RELOAD : tx_tmr_ff - 16'h1;

   assign tx_ready_out = tx_left_ff == '0;
   assign tx_line_out = tx_sh_ff[0];

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         tx_sh_ff <= '1;
         tx_left_ff <= '0;
         tx_tmr_ff <= '0;
      end else begin
         tx_sh_ff <= nxt_tx_sh;
         tx_left_ff <= nxt_tx_left;
         tx_tmr_ff <= nxt_tx_tmr;
      end
   end

   // Receiver: samples mid-bit; a start bit gone high at mid-bit is a glitch
   mgu_rx_state_t rx_st_ff;
   mgu_byte_t rx_sh_ff;
   logic [3:0] rx_left_ff;
   mgu_tmr_t rx_tmr_ff;
   logic rx_valid_ff;
   logic rx_err_ff;
   wire logic rx_start = (rx_st_ff == MGU_RX_IDLE) & (rx_line_in == `MGU_START_BIT);
   wire logic rx_samp = (rx_st_ff == MGU_RX_RUN) & (rx_tmr_ff == '0);
   wire logic rx_false = rx_samp & (rx_left_ff == FRAME) & rx_line_in;
   wire logic rx_last = rx_samp & (rx_left_ff == 4'h1);
   wire logic rx_data_bit = rx_samp & (rx_left_ff != FRAME) & (rx_left_ff != 4'h1);
   wire mgu_rx_state_t nxt_rx_st = rx_start ? MGU_RX_RUN :
      (rx_false | rx_last) ? MGU_RX_IDLE : rx_st_ff;
   wire mgu_byte_t nxt_rx_sh = rx_data_bit ? {rx_line_in, rx_sh_ff[7:1]} : rx_sh_ff;
   wire logic [3:0] nxt_rx_left = rx_start ? FRAME : rx_samp ? rx_left_ff - 4'h1 : rx_left_ff;
   wire mgu_tmr_t nxt_rx_tmr = rx_start ? HALF : rx_samp ? RELOAD : rx_tmr_ff - 16'h1;

   assign rx_data_out = rx_sh_ff;
   assign rx_valid_out = rx_valid_ff;
   assign rx_err_out = rx_err_ff;

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         rx_st_ff <= MGU_RX_IDLE;
         rx_sh_ff <= '0;
         rx_left_ff <= '0;
         rx_tmr_ff <= '0;
         rx_valid_ff <= 1'b0;
         rx_err_ff <= 1'b0;
      end else begin
         rx_st_ff <= nxt_rx_st;
         rx_sh_ff <= nxt_rx_sh;
         rx_left_ff <= nxt_rx_left;
         rx_tmr_ff <= nxt_rx_tmr;
         rx_valid_ff <= rx_last;
         rx_err_ff <= rx_last ? (rx_line_in != `MGU_STOP_BIT) : rx_err_ff;
      end
   end
endmodule

module mgu_dev import mgu_pkg::*; #(
   parameter bit HAS_NAV = 1'b1,
   parameter int MAIN_DIV = mgu_div(`MGU_MAIN_BAUD),
   parameter int NAV_BIN_DIV = mgu_div(`MGU_NAV_BIN_BAUD),
   parameter int NAV_TXT_DIV = mgu_div(`MGU_NAV_TXT_BAUD),
   parameter int TX_DEPTH = `MGU_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Link to the host
   mgu_link_if.dev link,
   // Main port status to and from the cellular side
   input wire logic carrier_present_in,
   input wire logic module_ready_in,
   input wire logic incoming_call_in,
   input wire logic can_receive_in,
   output logic terminal_ready_out,
   // Main port data
   input wire mgu_byte_t main_tx_data_in,
   input wire logic main_tx_valid_in,
   output logic main_tx_ready_out,
   output mgu_byte_t main_rx_data_out,
   output logic main_rx_valid_out,
   output logic main_rx_err_out,
   // Secondary port data
   input wire mgu_byte_t sec_tx_data_in,
   input wire logic sec_tx_valid_in,
   output logic sec_tx_ready_out,
   output mgu_byte_t sec_rx_data_out,
   output logic sec_rx_valid_out,
   // Binary positioning port data
   input wire mgu_byte_t bin_tx_data_in,
   input wire logic bin_tx_valid_in,
   output logic bin_tx_ready_out,
   output mgu_byte_t bin_rx_data_out,
   output logic bin_rx_valid_out,
   // Text positioning port data
   input wire mgu_byte_t txt_tx_data_in,
   input wire logic txt_tx_valid_in,
   output logic txt_tx_ready_out,
   output mgu_byte_t txt_rx_data_out,
   output logic txt_rx_valid_out
);
   mgu_byte_t fifo_data;
   logic fifo_valid;
   logic uart_ready;
   logic bin_line;
   logic txt_line;
   logic bin_ready;
   logic txt_ready;
   logic bin_valid;
   logic txt_valid;
   logic carrier_n_ff;
   logic set_ready_n_ff;
   logic ring_n_ff;
   logic clear_n_ff;
   logic term_ff;

   // Host request-to-send is checked only at a character boundary
   wire logic host_ready = link.request_send_n == `MGU_HS_ON;
   wire logic fifo_pop = uart_ready & host_ready;

   mgu_fifo #(.WIDTH(`MGU_DATA_BITS), .DEPTH(TX_DEPTH)) u_tx_fifo (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .in_data_in(main_tx_data_in),
      .in_valid_in(main_tx_valid_in),
      .in_ready_out(main_tx_ready_out),
      .out_data_out(fifo_data),
      .out_valid_out(fifo_valid),
      .out_ready_in(fifo_pop)
   );

   mgu_uart #(.DIV(MAIN_DIV)) u_main (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(fifo_data),
      .tx_valid_in(fifo_valid & host_ready),
      .tx_ready_out(uart_ready),
      .rx_data_out(main_rx_data_out),
      .rx_valid_out(main_rx_valid_out),
      .rx_err_out(main_rx_err_out),
      .tx_line_out(link.main_to_host),
      .rx_line_in(link.main_to_dev)
   );

   mgu_uart #(.DIV(NAV_BIN_DIV)) u_sec (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(sec_tx_data_in),
      .tx_valid_in(sec_tx_valid_in),
      .tx_ready_out(sec_tx_ready_out),
      .rx_data_out(sec_rx_data_out),
      .rx_valid_out(sec_rx_valid_out),
      .rx_err_out(),
      .tx_line_out(link.sec_tx),
      .rx_line_in(link.sec_rx)
   );

   mgu_uart #(.DIV(NAV_BIN_DIV)) u_bin (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(bin_tx_data_in),
      .tx_valid_in(bin_tx_valid_in & HAS_NAV),
      .tx_ready_out(bin_ready),
      .rx_data_out(bin_rx_data_out),
      .rx_valid_out(bin_valid),
      .rx_err_out(),
      .tx_line_out(bin_line),
      .rx_line_in(link.nav_binary_rx)
   );

   mgu_uart #(.DIV(NAV_TXT_DIV)) u_txt (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(txt_tx_data_in),
      .tx_valid_in(txt_tx_valid_in & HAS_NAV),
      .tx_ready_out(txt_ready),
      .rx_data_out(txt_rx_data_out),
      .rx_valid_out(txt_valid),
      .rx_err_out(),
      .tx_line_out(txt_line),
      .rx_line_in(link.nav_text_rx)
   );

   // Without the positioning receiver its ports stay idle and accept nothing
   assign link.nav_binary_tx = HAS_NAV ? bin_line : `MGU_LINE_IDLE;
   assign link.nav_text_tx = HAS_NAV ? txt_line : `MGU_LINE_IDLE;
   assign bin_tx_ready_out = bin_ready & HAS_NAV;
   assign txt_tx_ready_out = txt_ready & HAS_NAV;
   assign bin_rx_valid_out = bin_valid & HAS_NAV;
   assign txt_rx_valid_out = txt_valid & HAS_NAV;

   assign link.carrier_n = carrier_n_ff;
   assign link.set_ready_n = set_ready_n_ff;
   assign link.ring_indicate_n = ring_n_ff;
   assign link.clear_send_n = clear_n_ff;
   assign terminal_ready_out = term_ff;

   // Handshakes leave reset deasserted, so the host holds off until told
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         carrier_n_ff <= `MGU_HS_OFF;
         set_ready_n_ff <= `MGU_HS_OFF;
         ring_n_ff <= `MGU_HS_OFF;
         clear_n_ff <= `MGU_HS_OFF;
         term_ff <= 1'b0;
      end else begin
         carrier_n_ff <= ~carrier_present_in;
         set_ready_n_ff <= ~module_ready_in;
         ring_n_ff <= ~incoming_call_in;
         clear_n_ff <= ~can_receive_in;
         term_ff <= link.terminal_ready_n == `MGU_HS_ON;
      end
   end
endmodule

// ### src/mgu_regs.svh
`ifndef MGU_REGS_SVH
`define MGU_REGS_SVH

// System clock rate in Hz (25 ns period)
`define MGU_CLK_HZ 40000000
// Default line rates in baud
`define MGU_MAIN_BAUD 115200
`define MGU_NAV_BIN_BAUD 57600
`define MGU_NAV_TXT_BAUD 4800
// Character framing: start, data, stop
`define MGU_DATA_BITS 8
`define MGU_FRAME_BITS 10
`define MGU_START_BIT 1'b0
`define MGU_STOP_BIT 1'b1
`define MGU_LINE_IDLE 1'b1
// Handshake lines are asserted low on the module pins
`define MGU_HS_ON 1'b0
`define MGU_HS_OFF 1'b1
// Transmit buffer depth in characters
`define MGU_FIFO_DEPTH 16
// Counter width for bit timers
`define MGU_TMR_W 16

`endif

// ### src/mgu_pkg.sv
`include "mgu_regs.svh"

package mgu_pkg;
   typedef logic [`MGU_DATA_BITS-1:0] mgu_byte_t;
   typedef logic [`MGU_TMR_W-1:0] mgu_tmr_t;
   typedef enum logic {MGU_RX_IDLE, MGU_RX_RUN} mgu_rx_state_t;

   // Clock cycles per bit, rounded down
   function automatic int mgu_div(input int baud);
      return `MGU_CLK_HZ / baud;
   endfunction
endpackage

// ### src/mgu_link_if.sv
`timescale 1ns/10ps

interface mgu_link_if;
   // Main modem port, pin levels (handshakes low when asserted)
   logic main_to_host;
   logic main_to_dev;
   logic carrier_n;
   logic terminal_ready_n;
   logic set_ready_n;
   logic request_send_n;
   logic clear_send_n;
   logic ring_indicate_n;
   // Secondary modem port and positioning ports
   logic sec_tx;
   logic sec_rx;
   logic nav_binary_tx;
   logic nav_binary_rx;
   logic nav_text_tx;
   logic nav_text_rx;

   modport dev (
      output main_to_host, carrier_n, set_ready_n, clear_send_n, ring_indicate_n,
      output sec_tx, nav_binary_tx, nav_text_tx,
      input main_to_dev, terminal_ready_n, request_send_n,
      input sec_rx, nav_binary_rx, nav_text_rx
   );
   modport host (
      input main_to_host, carrier_n, set_ready_n, clear_send_n, ring_indicate_n,
      input sec_tx, nav_binary_tx, nav_text_tx,
      output main_to_dev, terminal_ready_n, request_send_n,
      output sec_rx, nav_binary_rx, nav_text_rx
   );
endinterface

// ### src/mgu_host.sv
`timescale 1ns/10ps
`include "mgu_regs.svh"

module mgu_fifo import mgu_pkg::*; #(
   parameter int WIDTH = `MGU_DATA_BITS,
   parameter int DEPTH = `MGU_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   // Drain side
   output logic [WIDTH-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("mgu_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   wire logic full = (wr_ptr_ff ^ rd_ptr_ff) == {1'b1, {AW{1'b0}}};
   wire logic empty = wr_ptr_ff == rd_ptr_ff;
   wire logic push = in_valid_in & ~full;
   wire logic pop = out_ready_in & ~empty;

   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem_ff[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
         rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
      end
   end
endmodule

module mgu_host import mgu_pkg::*; #(
   parameter bit USE_HANDSHAKE = 1'b1,
   parameter bit NAV_CROSS = 1'b1,
   parameter int MAIN_DIV = mgu_div(`MGU_MAIN_BAUD),
   parameter int NAV_BIN_DIV = mgu_div(`MGU_NAV_BIN_BAUD),
   parameter int NAV_TXT_DIV = mgu_div(`MGU_NAV_TXT_BAUD)
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Link to the device
   mgu_link_if.host link,
   // Main port control and status
   input wire logic terminal_ready_in,
   input wire logic can_receive_in,
   output logic carrier_out,
   output logic set_ready_out,
   output logic ring_out,
   output logic clear_send_out,
   // Main port data
   input wire mgu_byte_t main_tx_data_in,
   input wire logic main_tx_valid_in,
   output logic main_tx_ready_out,
   output mgu_byte_t main_rx_data_out,
   output logic main_rx_valid_out,
   output logic main_rx_err_out,
   // Binary positioning port data, used when not cross-wired
   input wire mgu_byte_t bin_tx_data_in,
   input wire logic bin_tx_valid_in,
   output logic bin_tx_ready_out,
   output mgu_byte_t bin_rx_data_out,
   output logic bin_rx_valid_out,
   // Text positioning port data
   input wire mgu_byte_t txt_tx_data_in,
   input wire logic txt_tx_valid_in,
   output logic txt_tx_ready_out,
   output mgu_byte_t txt_rx_data_out,
   output logic txt_rx_valid_out
);
   logic main_ready;
   logic bin_line;
   logic bin_ready;
   logic bin_valid;
   logic status_ff [4];
   logic dtr_n_ff;
   logic rts_n_ff;

   // Minimal host ignores clear-to-send and relies on software flow control
   wire logic may_send = ~USE_HANDSHAKE | (link.clear_send_n == `MGU_HS_ON);
   assign main_tx_ready_out = main_ready & may_send;

   mgu_uart #(.DIV(MAIN_DIV)) u_main (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(main_tx_data_in),
      .tx_valid_in(main_tx_valid_in & may_send),
      .tx_ready_out(main_ready),
      .rx_data_out(main_rx_data_out),
      .rx_valid_out(main_rx_valid_out),
      .rx_err_out(main_rx_err_out),
      .tx_line_out(link.main_to_dev),
      .rx_line_in(link.main_to_host)
   );

   mgu_uart #(.DIV(NAV_BIN_DIV)) u_bin (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(bin_tx_data_in),
      .tx_valid_in(bin_tx_valid_in & ~NAV_CROSS),
      .tx_ready_out(bin_ready),
      .rx_data_out(bin_rx_data_out),
      .rx_valid_out(bin_valid),
      .rx_err_out(),
      .tx_line_out(bin_line),
      .rx_line_in(link.nav_binary_tx)
   );

   mgu_uart #(.DIV(NAV_TXT_DIV)) u_txt (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tx_data_in(txt_tx_data_in),
      .tx_valid_in(txt_tx_valid_in),
      .tx_ready_out(txt_tx_ready_out),
      .rx_data_out(txt_rx_data_out),
      .rx_valid_out(txt_rx_valid_out),
      .rx_err_out(),
      .tx_line_out(link.nav_text_rx),
      .rx_line_in(link.nav_text_tx)
   );

   // Cross-wiring is pure wiring; it adds no delay between the two ports
   assign link.nav_binary_rx = NAV_CROSS ? link.sec_tx : bin_line;
   assign link.sec_rx = NAV_CROSS ? link.nav_binary_tx : `MGU_LINE_IDLE;
   assign bin_tx_ready_out = bin_ready & ~NAV_CROSS;
   assign bin_rx_valid_out = bin_valid & ~NAV_CROSS;

   assign link.terminal_ready_n = dtr_n_ff;
   assign link.request_send_n = rts_n_ff;
   assign carrier_out = status_ff[0];
   assign set_ready_out = status_ff[1];
   assign ring_out = status_ff[2];
   assign clear_send_out = status_ff[3];

   // Minimal host leaves its control lines asserted as if strapped
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         dtr_n_ff <= `MGU_HS_OFF;
         rts_n_ff <= `MGU_HS_OFF;
         status_ff <= '{default: 1'b0};
      end else begin
         dtr_n_ff <= USE_HANDSHAKE ? ~terminal_ready_in : `MGU_HS_ON;
         rts_n_ff <= USE_HANDSHAKE ? ~can_receive_in : `MGU_HS_ON;
         status_ff[0] <= link.carrier_n == `MGU_HS_ON;
         status_ff[1] <= link.set_ready_n == `MGU_HS_ON;
         status_ff[2] <= link.ring_indicate_n == `MGU_HS_ON;
         status_ff[3] <= link.clear_send_n == `MGU_HS_ON;
      end
   end
endmodule

// ### dv/mgu_link_assertions.sv
`timescale 1ns/10ps

module mgu_link_assertions #(
   parameter int MAIN_DIV = 8
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Main port
   input wire logic main_to_host,
   input wire logic main_to_dev,
   input wire logic carrier_n,
   input wire logic terminal_ready_n,
   input wire logic set_ready_n,
   input wire logic request_send_n,
   input wire logic clear_send_n,
   input wire logic ring_indicate_n,
   // Secondary and positioning ports
   input wire logic sec_tx,
   input wire logic sec_rx,
   input wire logic nav_binary_tx,
   input wire logic nav_binary_rx,
   input wire logic nav_text_tx,
   input wire logic nav_text_rx
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   // Frame tracker for the device transmit line; cnt 0 is the second start sample
   logic m_busy_ff;
   logic [15:0] m_cnt_ff;
   wire logic frame_end = m_busy_ff && (m_cnt_ff == 16'(10 * MAIN_DIV - 2));
   wire logic nxt_busy = m_busy_ff ? !frame_end : !main_to_host;
   wire logic [15:0] nxt_cnt = (m_busy_ff && !frame_end) ? m_cnt_ff + 16'h1 : 16'h0;

   always_ff @(posedge sys_clk_in) begin
      m_busy_ff <= reset_in ? 1'b0 : nxt_busy;
      m_cnt_ff <= reset_in ? 16'h0 : nxt_cnt;
   end

   sequence s_new_frame;
      !m_busy_ff && !main_to_host;
   endsequence

   sequence s_bit_low(logic line);
      !line [*3];
   endsequence

   property p_bit_len(logic line);
      $fell(line) |=> s_bit_low(line);
   endproperty

   AST_START_LOW: assert property (
      m_busy_ff && m_cnt_ff < 16'(MAIN_DIV - 1) |-> !main_to_host)
      else $error("start bit not low for a whole bit time");
   AST_STOP_HIGH: assert property (
      m_busy_ff && m_cnt_ff >= 16'(9 * MAIN_DIV - 1) |-> main_to_host)
      else $error("stop bit not high");
   AST_FLOW_GATE: assert property (
      s_new_frame |-> !$past(request_send_n) || !$past(request_send_n, 2))
      else $error("character started while request to send withdrawn");
   AST_RESET_IDLE: assert property ($fell(reset_in) |->
      main_to_host && main_to_dev && sec_tx && nav_binary_tx && nav_text_tx && nav_text_rx)
      else $error("serial line not idle high after reset");
   AST_RESET_HS: assert property ($fell(reset_in) |->
      carrier_n && set_ready_n && ring_indicate_n && clear_send_n && terminal_ready_n
      && request_send_n)
      else $error("handshake asserted out of reset");
   AST_CROSS_BIN: assert property (nav_binary_rx == sec_tx)
      else $error("secondary transmit not routed to binary receive");
   AST_CROSS_SEC: assert property (sec_rx == nav_binary_tx)
      else $error("binary transmit not routed to secondary receive");
   AST_TXT_BITLEN: assert property (p_bit_len(nav_text_tx))
      else $error("text port bit too short");
   AST_HOST_BITLEN: assert property (p_bit_len(main_to_dev))
      else $error("host transmit bit too short");
endmodule

// ### dv/modem_and_gps_uart_ports_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module modem_and_gps_uart_ports_tb import mgu_pkg::*; ;
   // Short divisors keep the run brief; all three differ to catch crossed rates
   localparam int MD = 8;
   localparam int BD = 12;
   localparam int TD = 16;
   typedef struct {int p; mgu_byte_t d;} mgu_row_t;
   // Path: 0 dev main, 1 host main, 2 dev sec, 3 dev bin, 4 dev txt, 5 host txt
   mgu_row_t rows [12] = '{'{0, 8'h00}, '{1, 8'hff}, '{2, 8'ha5}, '{3, 8'h5a}, '{4, 8'h01},
      '{5, 8'h80}, '{0, 8'hc3}, '{1, 8'h3c}, '{2, 8'hff}, '{3, 8'h00}, '{4, 8'h7e}, '{5, 8'h81}};
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   int n_errors = 0;
   int check_count = 0;
   logic [5:0] vld = 6'h00;
   mgu_byte_t td = 8'h00;
   logic [4:0] hs = 5'h1f;
   logic host_rx_en = 1'b1;
   logic wsel = 1'b0;
   wire logic [5:0] rdy;
   wire logic [5:0] rxv;
   mgu_byte_t rxd [6];
   wire logic [3:0] h_st;
   wire logic d_term;
   wire logic d_err;

   always #12.5 sys_clk_in = ~sys_clk_in;

   mgu_link_if link();
   wire logic wline = wsel ? link.nav_text_tx : link.main_to_host;
   wire logic [3:0] d_hs_n = {link.clear_send_n, link.ring_indicate_n, link.set_ready_n,
      link.carrier_n};

   mgu_dev #(.MAIN_DIV(MD), .NAV_BIN_DIV(BD), .NAV_TXT_DIV(TD)) u_mgu_dev (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link),
      .carrier_present_in(hs[0]), .module_ready_in(hs[1]), .incoming_call_in(hs[2]),
      .can_receive_in(hs[3]), .terminal_ready_out(d_term),
      .main_tx_data_in(td), .main_tx_valid_in(vld[0]), .main_tx_ready_out(rdy[0]),
      .main_rx_data_out(rxd[1]), .main_rx_valid_out(rxv[1]), .main_rx_err_out(d_err),
      .sec_tx_data_in(td), .sec_tx_valid_in(vld[2]), .sec_tx_ready_out(rdy[2]),
      .sec_rx_data_out(rxd[3]), .sec_rx_valid_out(rxv[3]),
      .bin_tx_data_in(td), .bin_tx_valid_in(vld[3]), .bin_tx_ready_out(rdy[3]),
      .bin_rx_data_out(rxd[2]), .bin_rx_valid_out(rxv[2]),
      .txt_tx_data_in(td), .txt_tx_valid_in(vld[4]), .txt_tx_ready_out(rdy[4]),
      .txt_rx_data_out(rxd[5]), .txt_rx_valid_out(rxv[5]));

   mgu_host #(.MAIN_DIV(MD), .NAV_BIN_DIV(BD), .NAV_TXT_DIV(TD)) u_mgu_host (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link),
      .terminal_ready_in(hs[4]), .can_receive_in(host_rx_en), .carrier_out(h_st[0]),
      .set_ready_out(h_st[1]), .ring_out(h_st[2]), .clear_send_out(h_st[3]),
      .main_tx_data_in(td), .main_tx_valid_in(vld[1]), .main_tx_ready_out(rdy[1]),
      .main_rx_data_out(rxd[0]), .main_rx_valid_out(rxv[0]), .main_rx_err_out(),
      .bin_tx_data_in(8'h00), .bin_tx_valid_in(1'b0), .bin_tx_ready_out(),
      .bin_rx_data_out(), .bin_rx_valid_out(),
      .txt_tx_data_in(td), .txt_tx_valid_in(vld[5]), .txt_tx_ready_out(rdy[5]),
      .txt_rx_data_out(rxd[4]), .txt_rx_valid_out(rxv[4]));

   mgu_link_assertions #(.MAIN_DIV(MD)) u_mgu_link_assertions (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .main_to_host(link.main_to_host), .main_to_dev(link.main_to_dev),
      .carrier_n(link.carrier_n), .terminal_ready_n(link.terminal_ready_n),
      .set_ready_n(link.set_ready_n), .request_send_n(link.request_send_n),
      .clear_send_n(link.clear_send_n), .ring_indicate_n(link.ring_indicate_n),
      .sec_tx(link.sec_tx), .sec_rx(link.sec_rx),
      .nav_binary_tx(link.nav_binary_tx), .nav_binary_rx(link.nav_binary_rx),
      .nav_text_tx(link.nav_text_tx), .nav_text_rx(link.nav_text_rx));

   task automatic end_sim;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Valid is held until ready is seen settled, then dropped after the taking edge
   task automatic put(input int p, input mgu_byte_t d);
      int n;
      @(negedge sys_clk_in);
      td = d;
      vld[p] = 1'b1;
      for (n = 0; n < 4000 && rdy[p] !== 1'b1; n++) @(negedge sys_clk_in);
      `CHK(rdy[p], 1'b1)
      @(negedge sys_clk_in);
      vld[p] = 1'b0;
   endtask

   task automatic grab(input int p, input mgu_byte_t d);
      int n;
      for (n = 0; n < 4000 && rxv[p] !== 1'b1; n++) @(negedge sys_clk_in);
      `CHK(rxv[p], 1'b1)
      `CHK(rxd[p], d)
      @(negedge sys_clk_in);
   endtask

   task automatic xfer(input int p, input mgu_byte_t d);
      fork
         put(p, d);
         grab(p, d);
      join
   endtask

   // Samples the line at bit centres, independent of the receiving end
   task automatic wire_chk(input bit txt, input mgu_byte_t d);
      int div;
      int k;
      logic [9:0] f;
      div = txt ? TD : MD;
      wsel = txt;
      fork
         put(txt ? 4 : 0, d);
      join_none
      for (k = 0; k < 4000 && wline !== 1'b0; k++) @(negedge sys_clk_in);
      repeat (div / 2) @(negedge sys_clk_in);
      for (k = 0; k < 10; k++) begin
         f[k] = wline;
         repeat (div) @(negedge sys_clk_in);
      end
      `CHK(f, {1'b1, d, 1'b0})
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk_in);
      n_errors++;
      end_sim;
   end

   initial begin
      repeat (8) @(negedge sys_clk_in);
      reset_in = 1'b0;
      foreach (rows[i]) xfer(rows[i].p, rows[i].d);
      wire_chk(1'b0, 8'h35);
      wire_chk(1'b1, 8'hc6);
      for (int v = 0; v < 32; v++) begin
         @(negedge sys_clk_in) hs = v[4:0];
         repeat (3) @(negedge sys_clk_in);
         `CHK(h_st, v[3:0])
         `CHK(d_hs_n, ~v[3:0])
         `CHK(d_term, v[4])
         `CHK(rdy[1], v[3])
      end
      // Host stalls: the buffer must fill without a character leaving
      host_rx_en = 1'b0;
      repeat (3) @(negedge sys_clk_in);
      for (int i = 0; i < 16; i++) put(0, 8'(i + 8'h40));
      repeat (2 * MD) @(negedge sys_clk_in);
      `CHK(rdy[0], 1'b0)
      `CHK(link.main_to_host, 1'b1)
      host_rx_en = 1'b1;
      for (int i = 0; i < 16; i++) grab(0, 8'(i + 8'h40));
      fork
         put(1, 8'h99);
      join_none
      repeat (3 * MD) @(negedge sys_clk_in);
      reset_in = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      `CHK({link.main_to_dev, link.main_to_host, rdy[0], d_term, h_st}, 8'he0)
      reset_in = 1'b0;
      xfer(1, 8'h66);
      `CHK(d_err, 1'b0)
      end_sim;
   end
endmodule
